// [verilog/port_mux_pkg.sv]
`default_nettype none
package port_mux_pkg;
  // function select codes
  localparam logic [3:0] FSEL_PROG_PAR = 4'h0;
  localparam logic [3:0] FSEL_PROG_SER = 4'h1;
  localparam logic [3:0] FSEL_FREQ_FULL = 4'h2;
  localparam logic [3:0] FSEL_FREQ_SWAP = 4'h3;
  localparam logic [3:0] FSEL_PH_SC = 4'h4;
  localparam logic [3:0] FSEL_SC_PH = 4'h5;
  localparam logic [3:0] FSEL_HI_SCH = 4'h6;
  localparam logic [3:0] FSEL_HI_PHH = 4'h7;
  localparam logic [3:0] FSEL_HI_SCL = 4'h8;
  localparam logic [3:0] FSEL_HI_PHL = 4'h9;
  localparam logic [3:0] FSEL_LO_SCH = 4'hA;
  localparam logic [3:0] FSEL_LO_PHH = 4'hB;
  localparam logic [3:0] FSEL_LO_SCL = 4'hC;
  localparam logic [3:0] FSEL_LO_PHL = 4'hD;
  // port sample rate divider: one port cycle per 24 clocks
  localparam int SAMPLE_DIV = 24;
  // extra stages on all three core word paths when latency matching is on
  localparam int MATCH_DEPTH = 2;
  // reset values
  localparam logic [31:0] FREQ_RESET = 32'h0000_0000;
  localparam logic [15:0] PHASE_RESET = 16'h0000;
  localparam logic [15:0] SCALE_RESET = 16'h0000;
  // fifo word layout: freq 32, phase 16, scale 16, scale enable 1
  localparam int CORE_WORD_W = 65;
endpackage
`default_nettype wire

// [verilog/dds_port_function_mux.sv]
`timescale 1ns/100ps
`default_nettype none

// small synchronous fifo between the word registers and the core
module core_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  // pointer and count bookkeeping
  always_comb begin
    push = in_valid && (cnt_r != (AW+1)'(DEPTH));
    pop = out_ready && (cnt_r != '0);
    wp_nxt = push ? wp_r + AW'(1) : wp_r;
    rp_nxt = pop ? rp_r + AW'(1) : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage has no reset; only written entries are ever read
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
endmodule

module dds_port_function_mux #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [31:0] port_data,
  input wire logic [3:0] func_sel,
  input wire logic streaming_enable,
  input wire logic scaling_enable,
  input wire logic matched_latency,
  input wire logic transfer_strobe,
  input wire logic core_ready,
  output logic sample_tick,
  output logic [3:0] port_mode,
  output logic [7:0] prog_data_hi,
  output logic [7:0] prog_data_lo,
  output logic [7:0] prog_addr,
  output logic [7:0] prog_ctrl,
  output logic prog_valid,
  output logic [7:0] serial_lines,
  output logic serial_valid,
  output logic [31:0] frequency_tuning_word,
  output logic [15:0] phase_offset_word,
  output logic [15:0] scale_word,
  output logic [31:0] core_freq,
  output logic [15:0] core_phase,
  output logic [15:0] core_scale,
  output logic core_valid,
  output logic words_stalled
);
  localparam int W = port_mux_pkg::CORE_WORD_W;

  // three-stage synchronisers on the pins; stage 1 feeds only stage 2
  logic [36:0] s1_r, s2_r, s3_r, pin_r, pin_nxt;
  logic [3:0] strb1_r, strb2_r, strb3_r, ctl_r, ctl_nxt;
  always_ff @(posedge sys_clk) begin
    s1_r <= {func_sel, port_data, 1'b0};
    s2_r <= s1_r;
    s3_r <= s2_r;
    strb1_r <= {transfer_strobe, streaming_enable, scaling_enable, matched_latency};
    strb2_r <= strb1_r;
    strb3_r <= strb2_r;
  end

  // accept a bit only once stages two and three agree
  always_comb begin
    pin_nxt = (s2_r & s3_r) | (pin_r & (s2_r | s3_r));
    ctl_nxt = (strb2_r & strb3_r) | (ctl_r & (strb2_r | strb3_r));
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_r <= '0;
      ctl_r <= '0;
    end else begin
      pin_r <= pin_nxt;
      ctl_r <= ctl_nxt;
    end
  end

  logic [31:0] pd;
  logic [3:0] fs;
  logic strobe_lvl, stream_en, scale_en, match_en;
  assign pd = pin_r[32:1];
  assign fs = pin_r[36:33];
  assign {strobe_lvl, stream_en, scale_en, match_en} = ctl_r;

  // port sample divider
  logic [4:0] div_r, div_nxt;
  logic tick;
  assign tick = (div_r == 5'(port_mux_pkg::SAMPLE_DIV - 1));
  always_comb begin
    div_nxt = tick ? 5'h00 : div_r + 5'h01;
  end

  // word registers and mode decode
  logic [31:0] freq_r, freq_nxt;
  logic [15:0] ph_r, ph_nxt, sc_r, sc_nxt;
  logic [7:0] pdh_r, pdh_nxt, pdl_r, pdl_nxt, pa_r, pa_nxt, pc_r, pc_nxt, ser_r, ser_nxt;
  logic pv_r, pv_nxt, sv_r, sv_nxt, dir_r, dir_nxt, tick_r, strobe_d_r;
  logic [3:0] mode_r, mode_nxt;
  always_comb begin
    freq_nxt = freq_r;
    ph_nxt = ph_r;
    sc_nxt = sc_r;
    pdh_nxt = pdh_r;
    pdl_nxt = pdl_r;
    pa_nxt = pa_r;
    pc_nxt = pc_r;
    ser_nxt = ser_r;
    pv_nxt = 1'b0;
    sv_nxt = 1'b0;
    dir_nxt = 1'b0;
    mode_nxt = mode_r;
    if (tick) begin
      mode_nxt = fs;
      case (fs)
        port_mux_pkg::FSEL_PROG_PAR: begin
          {pdh_nxt, pdl_nxt, pa_nxt, pc_nxt} = pd;
          pv_nxt = 1'b1;
        end
        port_mux_pkg::FSEL_PROG_SER: begin
          ser_nxt = pd[7:0];
          sv_nxt = 1'b1;
        end
        port_mux_pkg::FSEL_FREQ_FULL: begin
          freq_nxt = pd;
          dir_nxt = 1'b1;
        end
        port_mux_pkg::FSEL_FREQ_SWAP: begin
          freq_nxt = {pd[15:0], pd[31:16]};
          dir_nxt = 1'b1;
        end
        port_mux_pkg::FSEL_PH_SC: begin
          ph_nxt = pd[31:16];
          sc_nxt = {4'h0, pd[11:0]};
          dir_nxt = 1'b1;
        end
        port_mux_pkg::FSEL_SC_PH: begin
          sc_nxt = {4'h0, pd[27:16]};
          ph_nxt = pd[15:0];
          dir_nxt = 1'b1;
        end
        port_mux_pkg::FSEL_HI_SCH, port_mux_pkg::FSEL_HI_PHH,
        port_mux_pkg::FSEL_HI_SCL, port_mux_pkg::FSEL_HI_PHL: begin
          freq_nxt[31:8] = pd[31:8];
          dir_nxt = 1'b1;
          if (fs == port_mux_pkg::FSEL_HI_SCH) sc_nxt[15:8] = pd[7:0];
          else if (fs == port_mux_pkg::FSEL_HI_PHH) ph_nxt[15:8] = pd[7:0];
          else if (fs == port_mux_pkg::FSEL_HI_SCL) sc_nxt[7:0] = pd[7:0];
          else ph_nxt[7:0] = pd[7:0];
        end
        port_mux_pkg::FSEL_LO_SCH, port_mux_pkg::FSEL_LO_PHH,
        port_mux_pkg::FSEL_LO_SCL, port_mux_pkg::FSEL_LO_PHL: begin
          freq_nxt[23:0] = pd[31:8];
          dir_nxt = 1'b1;
          if (fs == port_mux_pkg::FSEL_LO_SCH) sc_nxt[15:8] = pd[7:0];
          else if (fs == port_mux_pkg::FSEL_LO_PHH) ph_nxt[15:8] = pd[7:0];
          else if (fs == port_mux_pkg::FSEL_LO_SCL) sc_nxt[7:0] = pd[7:0];
          else ph_nxt[7:0] = pd[7:0];
        end
        default: begin
          dir_nxt = 1'b0; // unused codes: port ignored
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_r <= 5'h00;
      freq_r <= port_mux_pkg::FREQ_RESET;
      ph_r <= port_mux_pkg::PHASE_RESET;
      sc_r <= port_mux_pkg::SCALE_RESET;
      pdh_r <= 8'h00;
      pdl_r <= 8'h00;
      pa_r <= 8'h00;
      pc_r <= 8'h00;
      ser_r <= 8'h00;
      pv_r <= 1'b0;
      sv_r <= 1'b0;
      dir_r <= 1'b0;
      mode_r <= 4'h0;
      tick_r <= 1'b0;
      strobe_d_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      freq_r <= freq_nxt;
      ph_r <= ph_nxt;
      sc_r <= sc_nxt;
      pdh_r <= pdh_nxt;
      pdl_r <= pdl_nxt;
      pa_r <= pa_nxt;
      pc_r <= pc_nxt;
      ser_r <= ser_nxt;
      pv_r <= pv_nxt;
      sv_r <= sv_nxt;
      dir_r <= dir_nxt;
      mode_r <= mode_nxt;
      tick_r <= tick;
      strobe_d_r <= strobe_lvl;
    end
  end

  // push to core on each direct sample when streaming, else on strobe rise
  logic push;
  logic fifo_in_ready, fifo_out_valid;
  logic [W-1:0] fifo_out;
  assign push = stream_en ? dir_r : (strobe_lvl && !strobe_d_r);

  core_fifo #(.WIDTH(W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_data({freq_r, ph_r, sc_r, scale_en}),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(core_ready)
  );

  // all three word paths delayed equally so the parameters land together
  logic [31:0] f_pipe_r [port_mux_pkg::MATCH_DEPTH];
  logic [15:0] p_pipe_r [port_mux_pkg::MATCH_DEPTH];
  logic [15:0] s_pipe_r [port_mux_pkg::MATCH_DEPTH];
  logic [port_mux_pkg::MATCH_DEPTH-1:0] v_pipe_r;
  logic [15:0] sc_gated;
  logic [31:0] cf_nxt;
  logic [15:0] cp_nxt, cs_nxt;
  logic cv_nxt;
  logic [31:0] cf_r;
  logic [15:0] cp_r, cs_r;
  logic cv_r, stall_r;

  // scale word forced to full scale while scaling is off
  assign sc_gated = fifo_out[0] ? {4'h0, fifo_out[12:1]} : 16'h0FFF;

  // all three words ride the same pipe so they land on one edge
  always_comb begin
    if (match_en) begin
      cf_nxt = f_pipe_r[port_mux_pkg::MATCH_DEPTH-1];
      cp_nxt = p_pipe_r[port_mux_pkg::MATCH_DEPTH-1];
      cs_nxt = s_pipe_r[port_mux_pkg::MATCH_DEPTH-1];
      cv_nxt = v_pipe_r[port_mux_pkg::MATCH_DEPTH-1];
    end else begin
      cf_nxt = fifo_out[64:33];
      cp_nxt = fifo_out[32:17];
      cs_nxt = sc_gated;
      cv_nxt = fifo_out_valid && core_ready;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      v_pipe_r <= '0;
      cf_r <= port_mux_pkg::FREQ_RESET;
      cp_r <= port_mux_pkg::PHASE_RESET;
      cs_r <= port_mux_pkg::SCALE_RESET;
      cv_r <= 1'b0;
      stall_r <= 1'b0;
    end else begin
      v_pipe_r <= {v_pipe_r[port_mux_pkg::MATCH_DEPTH-2:0], fifo_out_valid && core_ready};
      if (cv_nxt) begin
        cf_r <= cf_nxt;
        cp_r <= cp_nxt;
        cs_r <= cs_nxt;
      end
      cv_r <= cv_nxt;
      stall_r <= push && !fifo_in_ready;
    end
  end

  // data pipes carry no control, so they need no reset
  always_ff @(posedge sys_clk) begin
    f_pipe_r[0] <= fifo_out[64:33];
    p_pipe_r[0] <= fifo_out[32:17];
    s_pipe_r[0] <= sc_gated;
    for (int i = 1; i < port_mux_pkg::MATCH_DEPTH; i++) begin
      f_pipe_r[i] <= f_pipe_r[i-1];
      p_pipe_r[i] <= p_pipe_r[i-1];
      s_pipe_r[i] <= s_pipe_r[i-1];
    end
  end

  // outputs straight from flip-flops
  assign sample_tick = tick_r;
  assign port_mode = mode_r;
  assign prog_data_hi = pdh_r;
  assign prog_data_lo = pdl_r;
  assign prog_addr = pa_r;
  assign prog_ctrl = pc_r;
  assign prog_valid = pv_r;
  assign serial_lines = ser_r;
  assign serial_valid = sv_r;
  assign frequency_tuning_word = freq_r;
  assign phase_offset_word = ph_r;
  assign scale_word = sc_r;
  assign core_freq = cf_r;
  assign core_phase = cp_r;
  assign core_scale = cs_r;
  assign core_valid = cv_r;
  assign words_stalled = stall_r;
endmodule
`default_nettype wire

// [test/port_host.sv]
`timescale 1ns/100ps
`default_nettype none
// host side of the port: applies one setting just after a sample, holds it
module port_host (
  input wire logic sys_clk,
  input wire logic sample_tick,
  input wire logic go,
  input wire logic [3:0] sel_in,
  input wire logic [31:0] data_in,
  output logic [31:0] port_data,
  output logic [3:0] func_sel,
  output logic done
);
  // apply on a tick so the whole 24-cycle window covers the synchroniser
  initial begin
    port_data = 32'h0000_0000;
    func_sel = 4'hE;
    done = 1'b0;
    forever begin
      @(posedge sys_clk);
      if (go) begin
        do @(posedge sys_clk); while (!sample_tick);
        port_data <= data_in;
        func_sel <= sel_in;
        do @(posedge sys_clk); while (!sample_tick);
        done <= 1'b1;
        @(posedge sys_clk);
        done <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [test/dds_port_function_mux_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module port_mux_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sample_tick,
  input wire logic [3:0] port_mode,
  input wire logic prog_valid,
  input wire logic serial_valid,
  input wire logic [31:0] frequency_tuning_word,
  input wire logic [15:0] phase_offset_word,
  input wire logic [15:0] scale_word,
  input wire logic core_valid,
  input wire logic words_stalled
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_TICK_PERIOD: assert property (sample_tick |-> ##24 sample_tick)
    else $error("sample period wrong");
  AST_TICK_GAP: assert property (sample_tick |=> !sample_tick [*8])
    else $error("sample tick too soon");
  AST_HOLD_OFF_TICK: assert property (!sample_tick |-> $stable(frequency_tuning_word))
    else $error("word moved between samples");
  AST_PROG_MODE: assert property (prog_valid |-> sample_tick && port_mode == 4'h0)
    else $error("program pulse outside mode 0");
  AST_SERIAL_MODE: assert property (serial_valid |-> sample_tick && port_mode == 4'h1)
    else $error("serial pulse outside mode 1");
  AST_NO_WORD_MODES: assert property (sample_tick && port_mode inside {4'h0, 4'h1, 4'hE, 4'hF}
    |-> $stable(frequency_tuning_word) && $stable(phase_offset_word) && $stable(scale_word))
    else $error("words changed in a non-direct mode");
  AST_FREQ_ONLY: assert property (sample_tick && port_mode inside {4'h2, 4'h3}
    |-> $stable(phase_offset_word) && $stable(scale_word)) else $error("frequency mode touched others");
  AST_PH_SC_ONLY: assert property (sample_tick && port_mode inside {4'h4, 4'h5}
    |-> $stable(frequency_tuning_word) && scale_word[15:12] == 4'h0) else $error("phase/scale mode wrong");
  AST_HI_KEEPS_LOW: assert property (sample_tick && port_mode inside {[4'h6:4'h9]}
    |-> $stable(frequency_tuning_word[7:0])) else $error("low frequency byte moved");
  AST_LO_KEEPS_TOP: assert property (sample_tick && port_mode inside {[4'hA:4'hD]}
    |-> $stable(frequency_tuning_word[31:24])) else $error("top frequency byte moved");
  COV_PROG: cover property (prog_valid);
  COV_SERIAL: cover property (serial_valid);
  COV_CORE: cover property (core_valid);
  COV_STALL: cover property (words_stalled);
endmodule
bind dds_port_function_mux port_mux_chk chk_i (.sys_clk, .rst, .sample_tick, .port_mode, .prog_valid,
  .serial_valid, .frequency_tuning_word, .phase_offset_word, .scale_word, .core_valid, .words_stalled);
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int DEPTH = 16;
  logic sys_clk, rst, streaming_enable, scaling_enable, matched_latency, transfer_strobe, core_ready;
  logic go, done, sample_tick, prog_valid, serial_valid, core_valid, words_stalled;
  logic [3:0] sel_in, func_sel, port_mode;
  logic [31:0] data_in, port_data, frequency_tuning_word, core_freq, exp_f;
  logic [7:0] prog_data_hi, prog_data_lo, prog_addr, prog_ctrl, serial_lines;
  logic [15:0] phase_offset_word, scale_word, core_phase, core_scale, exp_p, exp_s;
  logic [63:0] last_core;
  int num_errors = 0;
  int total_checks = 0;
  int n_core = 0;
  int n_stall = 0;
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  dds_port_function_mux #(.FIFO_DEPTH(DEPTH)) uut (.sys_clk, .rst, .port_data, .func_sel, .streaming_enable,
    .scaling_enable, .matched_latency, .transfer_strobe, .core_ready, .sample_tick, .port_mode, .prog_data_hi,
    .prog_data_lo, .prog_addr, .prog_ctrl, .prog_valid, .serial_lines, .serial_valid, .frequency_tuning_word,
    .phase_offset_word, .scale_word, .core_freq, .core_phase, .core_scale, .core_valid, .words_stalled);
  port_host host (.sys_clk, .sample_tick, .go, .sel_in, .data_in, .port_data, .func_sel, .done);
  // tally deliveries to the core and dropped pushes
  always @(posedge sys_clk) begin
    if (core_valid) begin
      n_core <= n_core + 1;
      last_core <= {core_freq, core_phase, core_scale};
    end
    if (words_stalled) n_stall <= n_stall + 1;
  end
  task automatic complete_run();
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic timeout(input string what);
    num_errors++;
    $display("[ERR] %s expected done seen timeout", what);
    complete_run();
  endtask
  // one host setting, held until the sample that takes it has landed
  task automatic put(input logic [3:0] s, input logic [31:0] d);
    int i;
    sel_in <= s;
    data_in <= d;
    go <= 1'b1;
    for (i = 0; i < 200 && done !== 1'b1; i++) @(posedge sys_clk);
    if (done !== 1'b1) timeout("host");
    go <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wait_core(input int target);
    int i;
    for (i = 0; i < 100 && n_core < target; i++) @(posedge sys_clk);
    if (n_core < target) timeout("core delivery");
  endtask
  // every code through the lane table, streaming off
  task automatic t_direct();
    logic [31:0] d;
    int c, base;
    base = n_core;
    for (c = 0; c < 16; c++) begin
      d = 32'h9E37_79B9 ^ {8{c[3:0]}};
      put(c[3:0], d);
      case (c)
        2: exp_f = d;
        3: exp_f = {d[15:0], d[31:16]};
        4: begin exp_p = d[31:16]; exp_s = {4'h0, d[11:0]}; end
        5: begin exp_s = {4'h0, d[27:16]}; exp_p = d[15:0]; end
        6, 7, 8, 9: exp_f[31:8] = d[31:8];
        10, 11, 12, 13: exp_f[23:0] = d[31:8];
        default: ;
      endcase
      case (c)
        6, 10: exp_s[15:8] = d[7:0];
        7, 11: exp_p[15:8] = d[7:0];
        8, 12: exp_s[7:0] = d[7:0];
        9, 13: exp_p[7:0] = d[7:0];
        default: ;
      endcase
      if (c == 0) chk("prog bytes", d, {prog_data_hi, prog_data_lo, prog_addr, prog_ctrl});
      if (c == 1) chk("serial lines", d[7:0], serial_lines);
      chk("mode", c, port_mode);
      chk("freq", exp_f, frequency_tuning_word);
      chk("phase", exp_p, phase_offset_word);
      chk("scale", exp_s, scale_word);
    end
    chk("held words unsent", base, n_core);
  endtask
  task automatic t_strobe();
    int base;
    base = n_core;
    transfer_strobe <= 1'b1;
    repeat (8) @(posedge sys_clk);
    transfer_strobe <= 1'b0;
    wait_core(base + 1);
    chk("strobe push", {exp_f, exp_p, 16'h0FFF}, last_core);
  endtask
  task automatic t_stream();
    int base;
    streaming_enable <= 1'b1;
    scaling_enable <= 1'b1;
    matched_latency <= 1'b1;
    base = n_core;
    put(4'h5, 32'h0ABC_1234);
    exp_p = 16'h1234;
    exp_s = 16'h0ABC;
    wait_core(base + 1);
    chk("stream push", {exp_f, exp_p, exp_s}, last_core);
    put(4'hE, 32'h0000_0000);
  endtask
  // fill with the core stalled, then drain
  task automatic t_fifo();
    int i, t, s0, base;
    core_ready <= 1'b0;
    put(4'h2, 32'h1357_9BDF);
    s0 = n_stall;
    t = 0;
    for (i = 0; i < 600 && n_stall == s0; i++) begin
      @(posedge sys_clk);
      if (sample_tick === 1'b1) t++;
    end
    chk("samples to full", DEPTH, t);
    put(4'hE, 32'h0000_0000);
    base = n_core;
    core_ready <= 1'b1;
    wait_core(base + DEPTH);
    chk("drained word", {32'h1357_9BDF, exp_p, exp_s}, last_core);
  endtask
  initial begin
    rst = 1'b1;
    go = 1'b0;
    sel_in = 4'hE;
    data_in = 32'h0000_0000;
    streaming_enable = 1'b0;
    scaling_enable = 1'b0;
    matched_latency = 1'b0;
    transfer_strobe = 1'b0;
    core_ready = 1'b1;
    exp_f = 32'h0000_0000;
    exp_p = 16'h0000;
    exp_s = 16'h0000;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    t_direct();
    t_strobe();
    t_stream();
    t_fifo();
    complete_run();
  end
endmodule
`default_nettype wire
